// *** rtl/seeb_front_end.sv ***
// Serial slave front end with 512 x 8 array
// Assumes host pins asynchronous to sys_clk, link clock at most 1 MHz
`timescale 1ns/10ps
module seeb_front_end
   import seeb_pkg::*;
#(
   parameter int DEPTH = SEEB_DEPTH
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   // Serial pins
   input  wire logic linkClk,
   input  wire logic selN,
   input  wire logic serialIn,
   input  wire logic holdN,
   input  wire logic wpN,
   output logic      serialOut,
   output logic      serialOutEn,
   // Status
   output logic      selected,
   output logic      writeLatch
);
   // ============================================================
   // Pin sampling
   seeb_pins_t pinRaw, pin;
   assign pinRaw = '{clk: linkClk, selN: selN, din: serialIn, holdN: holdN, wpN: wpN};
   seeb_sync #(.W(5), .INIT(5'h0F)) uSync (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .pinIn   (pinRaw),
      .pinOut  (pin)
   );

   // ============================================================
   // Array, declared here as plain memory
   logic [7:0] mem [DEPTH];
   seeb_wreq_t wreq;

   // ============================================================
   // Serial state
   seeb_state_t state_r, state_nxt;
   logic             sel_r, sel_nxt, hold_r, hold_nxt, wel_r, wel_nxt;
   logic [1:0]       bp_r, bp_nxt;
   logic [2:0]       bit_r, bit_nxt;
   logic [7:0]       sh_r, sh_nxt, op_r, op_nxt;
   logic [SEEB_AW-1:0] addr_r, addr_nxt;
   logic             q_r, q_nxt, qEn_r, qEn_nxt;
   logic             clkD_r, selD_r, holdD_r;
   logic             rise, fall, selFall, selRise, holdFall, holdRise, step;
   logic [7:0]       shIn, statByte;

   assign rise     = pin.clk & ~clkD_r;
   assign fall     = ~pin.clk & clkD_r;
   assign selFall  = ~pin.selN & selD_r;
   assign selRise  = pin.selN & ~selD_r;
   assign holdFall = ~pin.holdN & holdD_r;
   assign holdRise = pin.holdN & ~holdD_r;
   assign shIn     = {sh_r[6:0], pin.din};
   assign statByte = {SEEB_STAT_ONES, bp_r, wel_r, 1'b0};

   function automatic logic opIs(input logic [7:0] op, input logic [7:0] code);
      return (op & SEEB_OP_MASK) == code;
   endfunction

   // Protected blocks: 01 upper quarter, 10 upper half, 11 all
   function automatic logic isProt(input logic [1:0] bp, input logic [SEEB_AW-1:0] a);
      unique case (bp)
         2'h0: return 1'b0;
         2'h1: return a[8] & a[7];
         2'h2: return a[8];
         2'h3: return 1'b1;
      endcase
   endfunction

   always_comb begin
      state_nxt = state_r;
      sel_nxt   = sel_r;
      hold_nxt  = hold_r;
      wel_nxt   = wel_r & pin.wpN;
      bp_nxt    = bp_r;
      bit_nxt   = bit_r;
      sh_nxt    = sh_r;
      op_nxt    = op_r;
      addr_nxt  = addr_r;
      q_nxt     = q_r;
      qEn_nxt   = qEn_r;
      wreq      = '0;
      step      = sel_r & ~hold_r & rise;
      // Select pin only counts while the clock is low
      if (!pin.clk && !clkD_r) begin
         if (selFall && !sel_r) begin
            sel_nxt   = 1'b1;
            hold_nxt  = 1'b0;
            state_nxt = SEEB_INSTR;
            bit_nxt   = '0;
            step      = 1'b0;
         end else if (selRise && sel_r) begin
            sel_nxt   = 1'b0;
            state_nxt = SEEB_IDLE;
            qEn_nxt   = 1'b0;
            step      = 1'b0;
            if (state_r == SEEB_WAIT && opIs(op_r, SEEB_OP_STSTORE) && wel_r && pin.wpN) begin
               bp_nxt  = sh_r[3:2];
               wel_nxt = 1'b0;
            end
         end
         if (sel_r && holdFall) begin
            hold_nxt = 1'b1;
            qEn_nxt  = 1'b0;
         end else if (sel_r && holdRise) begin
            hold_nxt = 1'b0;
            qEn_nxt  = (state_r == SEEB_RDATA || state_r == SEEB_STOUT);
         end
      end
      if (step) begin
         bit_nxt = bit_r + 3'h1;
         sh_nxt  = shIn;
         unique case (state_r)
            SEEB_INSTR: if (bit_r == SEEB_BIT_LAST) begin
               op_nxt = shIn;
               if (opIs(shIn, SEEB_OP_SETWL)) begin
                  wel_nxt = pin.wpN; state_nxt = SEEB_WAIT;
               end else if (opIs(shIn, SEEB_OP_CLRWL)) begin
                  wel_nxt = 1'b0; state_nxt = SEEB_WAIT;
               end else if (opIs(shIn, SEEB_OP_STFETCH)) begin
                  state_nxt = SEEB_STOUT; sh_nxt = statByte;
               end else if (opIs(shIn, SEEB_OP_STSTORE)) begin
                  state_nxt = SEEB_STIN;
               end else if (opIs(shIn, SEEB_OP_READ) || opIs(shIn, SEEB_OP_WRITE)) begin
                  state_nxt = SEEB_ADDR; addr_nxt[8] = shIn[3];
               end else begin
                  sel_nxt = 1'b0; state_nxt = SEEB_IDLE;
               end
            end
            SEEB_ADDR: if (bit_r == SEEB_BIT_LAST) begin
               addr_nxt[7:0] = shIn;
               if (opIs(op_r, SEEB_OP_READ)) begin
                  state_nxt = SEEB_RDATA;
                  sh_nxt    = mem[{addr_r[8], shIn}];
               end else begin
                  state_nxt = SEEB_WDATA;
               end
            end
            SEEB_WDATA: if (bit_r == SEEB_BIT_LAST) begin
               // Simplified: each byte stored at once, page wrap kept
               wreq.en   = wel_r & pin.wpN & ~isProt(bp_r, addr_r);
               wreq.addr = addr_r;
               wreq.data = shIn;
               addr_nxt  = {addr_r[8:4], addr_r[3:0] + 4'h1};
            end
            SEEB_RDATA: begin
               sh_nxt = {sh_r[6:0], 1'b0};
               if (bit_r == SEEB_BIT_LAST) begin
                  addr_nxt = addr_r + 9'h001;
                  sh_nxt   = mem[addr_r + 9'h001];
               end
            end
            SEEB_STOUT: begin
               sh_nxt = {sh_r[6:0], 1'b0};
               if (bit_r == SEEB_BIT_LAST) state_nxt = SEEB_WAIT;
            end
            SEEB_STIN: if (bit_r == SEEB_BIT_LAST) state_nxt = SEEB_WAIT;
            default: ;
         endcase
      end
      // Output moves only on the falling link clock edge
      if (sel_r && !hold_r && fall) begin
         qEn_nxt = (state_r == SEEB_RDATA || state_r == SEEB_STOUT);
         q_nxt   = sh_r[7];
      end
      if (!sel_nxt) qEn_nxt = 1'b0;
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= SEEB_IDLE;
         sel_r   <= 1'b0;
         hold_r  <= 1'b0;
         wel_r   <= 1'b0;
         bp_r    <= 2'h0;
         bit_r   <= 3'h0;
         sh_r    <= 8'h00;
         op_r    <= 8'h00;
         addr_r  <= '0;
         q_r     <= 1'b0;
         qEn_r   <= 1'b0;
         clkD_r  <= 1'b0;
         selD_r  <= 1'b1;
         holdD_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         sel_r   <= sel_nxt;
         hold_r  <= hold_nxt;
         wel_r   <= wel_nxt;
         bp_r    <= bp_nxt;
         bit_r   <= bit_nxt;
         sh_r    <= sh_nxt;
         op_r    <= op_nxt;
         addr_r  <= addr_nxt;
         q_r     <= q_nxt;
         qEn_r   <= qEn_nxt;
         clkD_r  <= pin.clk;
         selD_r  <= pin.selN;
         holdD_r <= pin.holdN;
      end
   end

   // Array has no reset; contents are non-volatile
   always_ff @(posedge sys_clk) begin
      if (wreq.en) mem[wreq.addr] <= wreq.data;
   end

   assign serialOut   = q_r;
   assign serialOutEn = qEn_r;
   assign selected    = sel_r;
   assign writeLatch  = wel_r;

   // ============================================================
   // Checks
   a_deselect_releases: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !sel_r |-> !qEn_r) else $error("output driven while deselected");
   a_select_clock_low: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $changed(sel_r) && sel_r |-> $past(!pin.clk)) else $error("selected with clock high");
   a_sel_ignore_high: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $past(pin.clk) && $past(sel_r) && $past(state_r) != SEEB_INSTR |-> sel_r)
      else $error("deselected while clock high");
   a_output_on_fall: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $changed(q_r) |-> $past(fall)) else $error("output changed off falling edge");
   a_restart_count: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !$past(sel_r) && sel_r |-> bit_r == 3'h0 && state_r == SEEB_INSTR)
      else $error("count not restarted");
   a_hold_freezes: assert property (@(posedge sys_clk) disable iff (sys_rst)
      hold_r && $past(hold_r) |-> $stable(bit_r) && !qEn_r) else $error("progress during hold");
   a_protect_latch: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !pin.wpN |=> !wel_r) else $error("latch set under write protect");
   a_bad_op_drop: assert property (@(posedge sys_clk) disable iff (sys_rst)
      step && state_r == SEEB_INSTR && bit_r == SEEB_BIT_LAST && shIn[7:4] != 4'h0 |=> !sel_r)
      else $error("invalid instruction kept selection");
   a_capture_rise: assert property (@(posedge sys_clk) disable iff (sys_rst)
      $changed(bit_r) && $past(sel_r) |-> $past(rise)) else $error("bit counted off rising edge");
   c_read: cover property (@(posedge sys_clk) state_r == SEEB_RDATA && qEn_r);
   c_status: cover property (@(posedge sys_clk) state_r == SEEB_STOUT && qEn_r);
   c_write: cover property (@(posedge sys_clk) wreq.en);
   c_hold: cover property (@(posedge sys_clk) hold_r && sel_r);
endmodule

// *** rtl/seeb_pkg.sv ***
// Constants and carrier types for the serial memory front end
// Assumes a 20 MHz system clock sampling all serial pins
package seeb_pkg;
   localparam int           SEEB_PAGES      = 32;
   localparam int           SEEB_PAGE_BYTES = 16;
   localparam int           SEEB_DEPTH      = SEEB_PAGES * SEEB_PAGE_BYTES;
   localparam int           SEEB_AW         = 9;
   localparam int           SEEB_SYS_HZ     = 20000000;
   localparam int           SEEB_LINK_MAX_HZ = 1000000;
   localparam int           SEEB_MIN_HALF   = SEEB_SYS_HZ / SEEB_LINK_MAX_HZ / 2;
   localparam logic [7:0]   SEEB_OP_MASK    = 8'hF7;
   localparam logic [7:0]   SEEB_OP_SETWL   = 8'h06;
   localparam logic [7:0]   SEEB_OP_CLRWL   = 8'h04;
   localparam logic [7:0]   SEEB_OP_STFETCH = 8'h05;
   localparam logic [7:0]   SEEB_OP_STSTORE = 8'h01;
   localparam logic [7:0]   SEEB_OP_READ    = 8'h03;
   localparam logic [7:0]   SEEB_OP_WRITE   = 8'h02;
   localparam logic [3:0]   SEEB_STAT_ONES  = 4'hF;
   localparam logic [2:0]   SEEB_BIT_LAST   = 3'h7;

   typedef enum logic [2:0] {
      SEEB_IDLE  = 3'b000,
      SEEB_INSTR = 3'b001,
      SEEB_ADDR  = 3'b010,
      SEEB_RDATA = 3'b011,
      SEEB_WDATA = 3'b100,
      SEEB_STOUT = 3'b101,
      SEEB_STIN  = 3'b110,
      SEEB_WAIT  = 3'b111
   } seeb_state_t;

   // Pin levels after synchronising
   typedef struct packed {
      logic clk;
      logic selN;
      logic din;
      logic holdN;
      logic wpN;
   } seeb_pins_t;

   // Memory write request
   typedef struct packed {
      logic               en;
      logic [SEEB_AW-1:0] addr;
      logic [7:0]         data;
   } seeb_wreq_t;
endpackage

// *** rtl/seeb_sync.sv ***
// Three-stage pin synchroniser with agreement filter
// Assumes asynchronous inputs; reset level given per bit
`timescale 1ns/10ps
module seeb_sync
   import seeb_pkg::*;
#(
   parameter int          W    = 5,
   parameter logic [4:0]  INIT = 5'h1F
) (
   // Clock and reset
   input  wire logic         sys_clk,
   input  wire logic         sys_rst,
   // Pins
   input  wire logic [W-1:0] pinIn,
   output logic      [W-1:0] pinOut
);
   logic [W-1:0] s1_r, s2_r, s3_r, out_r;
   logic [W-1:0] out_nxt;

   // Change accepted only once stages two and three agree
   always_comb begin
      out_nxt = out_r;
      for (int i = 0; i < W; i++) begin
         if (s2_r[i] == s3_r[i]) begin
            out_nxt[i] = s3_r[i];
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_r  <= INIT[W-1:0];
         s2_r  <= INIT[W-1:0];
         s3_r  <= INIT[W-1:0];
         out_r <= INIT[W-1:0];
      end else begin
         s1_r  <= pinIn;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         out_r <= out_nxt;
      end
   end
   assign pinOut = out_r;
endmodule

// *** tb/seeb_host.sv ***
// Host model driving the serial pins of the memory front end
// Assumes the bench supplies sys_clk and resolves the output pin
`timescale 1ns/10ps
module seeb_host #(
   parameter int HALF = 4
) (
   // Clock
   input  wire logic sys_clk,
   // Serial pins
   output logic      linkClk,
   output logic      selN,
   output logic      serialIn,
   output logic      holdN,
   output logic      wpN,
   input  wire logic pinQ
);
   // =====================================
   // Pin driving
   initial begin
      linkClk  = 1'b0;
      selN     = 1'b1;
      serialIn = 1'b0;
      holdN    = 1'b1;
      wpN      = 1'b1;
   end
   task automatic hc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // Select edges only with the clock low; select stays low for a whole operation
   task automatic pick(input logic lvl);
      hc(HALF);
      selN = lvl;
      if (lvl)
         serialIn = ~serialIn;
      hc(2 * HALF);
   endtask
   // Read bit taken late in the high phase: the output settles several cycles after the fall
   task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i >= 8 - nb; i--) begin
         serialIn = tx[i];
         hc(HALF);
         linkClk = 1'b1;
         hc(HALF - 1);
         rx[i] = pinQ;
         hc(1);
         linkClk = 1'b0;
      end
   endtask
   task automatic hold(input logic lvl);
      hc(HALF);
      holdN = lvl;
      hc(2 * HALF);
   endtask
   task automatic pulses(input int n);
      repeat (n) begin
         linkClk = 1'b1;
         hc(HALF);
         linkClk = 1'b0;
         hc(HALF);
      end
   endtask
   // Select toggled and restored inside one high phase
   task automatic blip();
      hc(HALF);
      linkClk = 1'b1;
      hc(2);
      selN = ~selN;
      hc(2);
      selN = ~selN;
      hc(2);
      linkClk = 1'b0;
      hc(HALF);
   endtask
   task automatic protect(input logic lvl);
      hc(1);
      wpN = lvl;
   endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the serial memory front end
// Assumes seeb_host drives every serial pin; output pin resolved here
`timescale 1ns/10ps
module tb;
   import seeb_pkg::*;
   // =====================================
   // Signals
   logic        sys_clk, sys_rst;
   wire logic   linkClk, selN, serialIn, holdN, wpN;
   wire logic   serialOut, serialOutEn, selected, writeLatch;
   wire         pinQ = serialOutEn ? serialOut : 1'bz;
   int          err_total = 0;
   int          compares  = 0;
   logic [31:0] seed      = 32'hA37B8571;
   logic [1:0]  bpx       = 2'b00;
   logic [7:0]  rx;
   logic [7:0]  mem [0:511];
   logic [8:0]  a;
   seeb_front_end i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .linkClk(linkClk), .selN(selN),
      .serialIn(serialIn), .holdN(holdN), .wpN(wpN), .serialOut(serialOut),
      .serialOutEn(serialOutEn), .selected(selected), .writeLatch(writeLatch));
   seeb_host i_host (.sys_clk(sys_clk), .linkClk(linkClk), .selN(selN), .serialIn(serialIn),
      .holdN(holdN), .wpN(wpN), .pinQ(pinQ));
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // =====================================
   // Helpers
   function automatic logic [7:0] rnd();
      seed = {seed[30:0], ^(seed & 32'h80200003)};
      return seed[7:0];
   endfunction
   // Block protect: 01 top quarter, 10 top half, 11 whole array
   function automatic logic prot(input logic [8:0] ad);
      return bpx == 2'b11 || (bpx == 2'b10 && ad[8]) || (bpx == 2'b01 && ad[8:7] == 2'b11);
   endfunction
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cmd(input logic [7:0] op, input int nb);
      i_host.pick(1'b0);
      i_host.xfer(op, nb, rx);
   endtask
   task automatic status(input logic wel);
      cmd(SEEB_OP_STFETCH, 8);
      i_host.xfer(8'h00, 8, rx);
      chk("status", rx, {SEEB_STAT_ONES, bpx, wel, 1'b0});
      i_host.pick(1'b1);
   endtask
   // Page write; the address wraps inside its 16-byte page
   task automatic wr(input logic [8:0] ad, input int n);
      logic [7:0] d;
      logic [8:0] p;
      p = ad;
      cmd(SEEB_OP_SETWL, 8);
      i_host.pick(1'b1);
      cmd(SEEB_OP_WRITE | {4'h0, ad[8], 3'h0}, 8);
      i_host.xfer(ad[7:0], 8, rx);
      for (int i = 0; i < n; i++) begin
         d = rnd();
         if (wpN === 1'b1 && !prot(p))
            mem[p] = d;
         i_host.xfer(d, 8, rx);
         p = {p[8:4], p[3:0] + 4'h1};
      end
      i_host.pick(1'b1);
   endtask
   // Status store; new protect bits commit at deselect
   task automatic blockSet(input logic [1:0] lvl);
      cmd(SEEB_OP_SETWL, 8);
      i_host.pick(1'b1);
      cmd(SEEB_OP_STSTORE, 8);
      i_host.xfer({4'h0, lvl, 2'b00}, 8, rx);
      i_host.pick(1'b1);
      bpx = lvl;
      status(1'b0);
   endtask
   task automatic rd(input logic [8:0] ad, input int n, input int holdAt);
      logic [8:0] p;
      p = ad;
      cmd(SEEB_OP_READ | {4'h0, ad[8], 3'h0}, 8);
      i_host.xfer(ad[7:0], 8, rx);
      for (int i = 0; i < n; i++) begin
         if (i == holdAt) begin
            i_host.hold(1'b0);
            chk("hold enable", {7'h0, serialOutEn}, 8'h00);
            i_host.pulses(2);
            i_host.hold(1'b1);
         end
         i_host.xfer(8'h00, 8, rx);
         chk("read data", rx, mem[p]);
         p = p + 9'h001;
      end
      i_host.pick(1'b1);
      chk("out enable", {7'h0, serialOutEn}, 8'h00);
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // =====================================
   // Sequence
   initial begin
      sys_rst = 1'b1;
      repeat (16) @(posedge sys_clk);
      #1;
      sys_rst = 1'b0;
      i_host.hc(10);
      chk("idle flags", {5'h0, selected, serialOutEn, writeLatch}, 8'h00);
      $display("test reset done");
      cmd(SEEB_OP_SETWL, 8);
      chk("selected", {7'h0, selected}, 8'h01);
      i_host.blip();
      chk("selected", {7'h0, selected}, 8'h01);
      i_host.pick(1'b1);
      chk("latch", {6'h0, selected, writeLatch}, 8'h01);
      status(1'b1);
      cmd(SEEB_OP_CLRWL | 8'h08, 8);
      i_host.pick(1'b1);
      status(1'b0);
      $display("test latch done");
      wr(9'h000, 4);
      wr(9'h1FC, 4);
      for (int k = 0; k < 3; k++) begin
         void'(rnd());
         a = seed[8:0];
         wr(a, 16);
         rd({a[8:4], 4'h0}, 16, -1);
      end
      rd(9'h1FE, 4, 1);
      $display("test array done");
      i_host.protect(1'b0);
      wr(9'h000, 2);
      i_host.protect(1'b1);
      rd(9'h000, 2, -1);
      $display("test protect done");
      wr(9'h180, 2);
      blockSet(2'b01);
      wr(9'h180, 2);
      wr(9'h17E, 2);
      rd(9'h17E, 4, -1);
      blockSet(2'b00);
      $display("test block protect done");
      cmd(8'hFF, 8);
      i_host.hc(10);
      chk("bad opcode", {7'h0, selected}, 8'h00);
      i_host.pick(1'b1);
      cmd(SEEB_OP_READ, 8);
      i_host.xfer(8'h00, 8, rx);
      i_host.xfer(8'h00, 3, rx);
      i_host.pick(1'b1);
      chk("abort enable", {7'h0, serialOutEn}, 8'h00);
      status(1'b0);
      $display("test abort done");
      results();
   end
   // Hang guard
   initial begin
      #3000000;
      err_total++;
      results();
   end
endmodule
